// ==== core/spr_port.sv ====
/*
 * Serial port register block: data and divisor latch, interrupt
 * enables, prioritised cause identification, queue control, scratch
 * byte and base decode. Assumes host strobes and line-side bytes are
 * on core_clk; the port select strap arrives asynchronously.
 */
`timescale 1ns/1ns
module spr_port
   import spr_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic [1:0] port_sel_pin,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   input wire logic rx_err,
   input wire logic modem_chg,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic baud_tick,
   output logic intr_pending
);
`include "spr_defines.svh"

   localparam int LW = $clog2(DEPTH) + 1;

   // Base address of the window for a select code
   function automatic logic [15:0] port_base(input logic [1:0] sel);
      logic [15:0] b;
      unique case (sel)
         2'h0: b = `SPR_BASE_0;
         2'h1: b = `SPR_BASE_1;
         2'h2: b = `SPR_BASE_2;
         2'h3: b = `SPR_BASE_3;
      endcase
      return b;
   endfunction

   // True when an address falls in the selected window
   function automatic logic addr_hit(input logic [15:0] a, input logic [1:0] sel);
      logic [15:0] b;
      b = port_base(sel);
      return a[15:3] == b[15:3];
   endfunction

   // Trigger level in bytes for a threshold code
   function automatic logic [5:0] trig_count(input spr_trig_t t);
      logic [5:0] c;
      unique case (t)
         2'h0: c = `SPR_TRIG_0;
         2'h1: c = `SPR_TRIG_1;
         2'h2: c = `SPR_TRIG_2;
         2'h3: c = `SPR_TRIG_3;
      endcase
      return c;
   endfunction

   spr_regs_s s;
   spr_regs_s next_s;
   spr_fifo_if #(.W(8), .LW(LW)) rxq ();
   spr_fifo_if #(.W(8), .LW(LW)) txq ();

   logic div_sel;
   logic [2:0] off;
   logic rd;
   logic wr;
   logic iir_rd;
   logic fcr_wr;
   logic p_tmo;
   logic p_ls;
   logic p_rda;
   logic p_thre;
   logic p_ms;
   logic pend;
   logic [2:0] code;
   logic [7:0] iir;
   logic rx_push;
   logic rx_pop;
   logic rda_now;
   logic rda_set;
   logic thre_set;
   logic tmo_set;

   spr_fifo #(.W(8), .DEPTH(DEPTH)) u_rxq (
      .core_clk(core_clk),
      .rst(rst),
      .q(rxq.fifo)
   );

   spr_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
      .core_clk(core_clk),
      .rst(rst),
      .q(txq.fifo)
   );

   spr_baud u_baud (
      .core_clk(core_clk),
      .rst(rst),
      .div(s.div),
      .tick(baud_tick)
   );

   assign div_sel = s.lcr[`SPR_LCR_DIV_SEL];
   assign off = io_addr[2:0];
   assign rd = io_rd & addr_hit(io_addr, s.port_sel);
   assign wr = io_wr & addr_hit(io_addr, s.port_sel);
   assign fcr_wr = wr & (off == `SPR_OFS_IIR);
   assign iir_rd = rd & (off == `SPR_OFS_IIR) & !div_sel;

   assign p_tmo = s.tmo_f & s.ier[`SPR_IER_RDA];
   assign p_ls = s.ls_f & s.ier[`SPR_IER_RLS];
   assign p_rda = s.rda_f & s.ier[`SPR_IER_RDA];
   assign p_thre = s.thre_f & s.ier[`SPR_IER_THRE];
   assign p_ms = s.ms_f & s.ier[`SPR_IER_MS];
   assign pend = p_tmo | p_ls | p_rda | p_thre | p_ms;

   always_comb begin
      if (p_tmo) begin
         code = `SPR_ID_TMO;
      end else if (p_ls) begin
         code = `SPR_ID_RLS;
      end else if (p_rda) begin
         code = `SPR_ID_RDA;
      end else if (p_thre) begin
         code = `SPR_ID_THRE;
      end else begin
         code = `SPR_ID_MS;
      end
   end

   assign iir = {{2{s.fifo_en}}, 2'b00, code, ~pend};

   // Queue hookups toward the line and the host
   assign rx_push = rx_valid & s.rx_ready;
   assign rx_pop = rd & (off == `SPR_OFS_DATA) & !div_sel & rxq.out_valid;
   assign rxq.in_valid = rx_push;
   assign rxq.in_data = rx_data;
   assign rxq.out_ready = rx_pop;
   assign rxq.flush = fcr_wr & (!io_wdata[`SPR_FCR_EN] | io_wdata[`SPR_FCR_RX_CLR]);
   assign txq.in_valid = wr & (off == `SPR_OFS_DATA) & !div_sel;
   assign txq.in_data = io_wdata;
   assign txq.out_ready = !s.tx_valid | tx_ready;
   assign txq.flush = fcr_wr & (!io_wdata[`SPR_FCR_EN] | io_wdata[`SPR_FCR_TX_CLR]);

   assign rda_now = s.fifo_en ? (rxq.level >= LW'(trig_count(s.trig))) : rxq.out_valid;
   assign rda_set = rda_now & !s.rda_lvl;
   assign thre_set = (txq.level == '0) & !s.tx_empty_q;
   assign tmo_set = baud_tick & rxq.out_valid & !rx_push & !rx_pop
                    & (s.idle_cnt == 10'(`SPR_TMO_TICKS - 1'b1));

   // Register file, cause flags and output stages
   always_comb begin
      next_s = s;
      // Strap passes three flops, taken when the last two agree
      next_s.sel_s1 = port_sel_pin;
      next_s.sel_s2 = s.sel_s1;
      next_s.sel_s3 = s.sel_s2;
      if (s.sel_s2 == s.sel_s3) begin
         next_s.port_sel = s.sel_s3;
      end
      if (wr) begin
         unique case (off)
            `SPR_OFS_DATA: begin
               if (div_sel) begin
                  next_s.div[7:0] = io_wdata;
               end
            end
            `SPR_OFS_IER: begin
               if (div_sel) begin
                  next_s.div[15:8] = io_wdata;
               end else begin
                  next_s.ier = {4'h0, io_wdata[3:0]};
               end
            end
            `SPR_OFS_IIR: begin
               next_s.fifo_en = io_wdata[`SPR_FCR_EN];
               next_s.trig = io_wdata[7:6];
            end
            `SPR_OFS_LCR: next_s.lcr = io_wdata;
            `SPR_OFS_SCR: next_s.scr = io_wdata;
            default: begin
            end
         endcase
      end
      if (rd) begin
         unique case (off)
            `SPR_OFS_DATA: next_s.rdata = div_sel ? s.div[7:0] : rxq.out_data;
            `SPR_OFS_IER: next_s.rdata = div_sel ? s.div[15:8] : s.ier;
            `SPR_OFS_IIR: next_s.rdata = div_sel ? 8'h00 : iir;
            `SPR_OFS_LCR: next_s.rdata = s.lcr;
            `SPR_OFS_SCR: next_s.rdata = s.scr;
            default: next_s.rdata = 8'h00;
         endcase
      end
      // read clears reported cause, set wins
      next_s.tmo_f = tmo_set | (s.tmo_f & !rx_pop & rxq.out_valid
                     & !(iir_rd & pend & code == `SPR_ID_TMO));
      next_s.ls_f = rx_err | (s.ls_f & !(iir_rd & pend & code == `SPR_ID_RLS));
      next_s.rda_f = rda_set | (s.rda_f & rda_now
                     & !(iir_rd & pend & code == `SPR_ID_RDA));
      next_s.thre_f = thre_set | (s.thre_f & !txq.in_valid
                      & !(iir_rd & pend & code == `SPR_ID_THRE));
      next_s.ms_f = modem_chg | (s.ms_f & !(iir_rd & pend & code == `SPR_ID_MS));
      next_s.rda_lvl = rda_now;
      next_s.tx_empty_q = txq.level == '0;
      // Idle counter in sixteenth-bit ticks
      if (!rxq.out_valid | rx_push | rx_pop | tmo_set) begin
         next_s.idle_cnt = 10'h000;
      end else if (baud_tick) begin
         next_s.idle_cnt = 10'(s.idle_cnt + 1'b1);
      end
      next_s.irq = pend;
      // Transmit output stage
      if (txq.out_ready) begin
         next_s.tx_valid = txq.out_valid;
         next_s.tx_data = txq.out_data;
      end
      // Receive space, one byte deep while queues are off
      if (s.fifo_en) begin
         next_s.rx_ready = rxq.level <= LW'(DEPTH - 2);
      end else begin
         next_s.rx_ready = (rxq.level == '0) & !rx_push;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign io_rdata = s.rdata;
   assign rx_ready = s.rx_ready;
   assign tx_valid = s.tx_valid;
   assign tx_data = s.tx_data;
   assign intr_pending = s.irq;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);

   div_map_a: assert property (
      rd && off == `SPR_OFS_DATA && div_sel |=> io_rdata == $past(s.div[7:0]))
      else $error("divisor low byte not mapped at base");
   rx_read_a: assert property (
      rx_pop |=> io_rdata == $past(rxq.out_data)
      && (rxq.level == $past(rxq.level) - 1'b1 || $past(rx_push)))
      else $error("received byte not returned on data read");
   ier_map_a: assert property (
      wr && off == `SPR_OFS_IER && !div_sel |=> s.ier == {4'h0, $past(io_wdata[3:0])})
      else $error("enable register not written at offset one");
   modem_gate_a: assert property (
      modem_chg && s.ier[`SPR_IER_MS] && !wr |=> pend)
      else $error("enabled modem change raises no cause");
   rls_gate_a: assert property (
      rx_err && s.ier[`SPR_IER_RLS] && !wr |=> pend && (code == `SPR_ID_RLS || p_tmo))
      else $error("enabled line status raises no cause");
   iir_top_a: assert property (
      iir_rd |=> io_rdata[7:6] == {2{$past(s.fifo_en)}} && io_rdata[5:4] == 2'b00)
      else $error("identification top bits wrong");
   iir_pend_a: assert property (
      iir_rd |=> io_rdata[0] == !$past(pend) && intr_pending == $past(pend))
      else $error("pending bit does not match causes");
   cause_prio_a: assert property (
      p_ls && !p_tmo |-> code == `SPR_ID_RLS && iir[3:1] == 3'h3)
      else $error("line status not given priority");
   ack_clear_a: assert property (
      iir_rd && pend && code == `SPR_ID_THRE && !thre_set |=> !s.thre_f)
      else $error("reported cause not cleared by read");
   trig_set_a: assert property (
      fcr_wr |=> s.trig == $past(io_wdata[7:6]) && s.fifo_en == $past(io_wdata[0]))
      else $error("trigger level not taken from control write");
   scratch_a: assert property (
      (wr && off == `SPR_OFS_SCR) ##1 !wr ##1 (rd && off == `SPR_OFS_SCR)
      |=> io_rdata == $past(io_wdata, 3))
      else $error("scratch byte not returned");
   base_miss_a: assert property (
      io_rd && !addr_hit(io_addr, s.port_sel) |=> io_rdata == $past(io_rdata))
      else $error("read outside window answered");
   flush_all_a: assert property (
      fcr_wr && !io_wdata[`SPR_FCR_EN] |=> rxq.level == '0 && txq.level == '0)
      else $error("queues not emptied on disable");
   timeout_a: assert property (
      $rose(s.tmo_f) |-> $past(rxq.out_valid) && $past(s.idle_cnt) == 10'h27f)
      else $error("timeout raised without idle data");

   // Main scenarios reached
   cover_tmo_c: cover property (iir_rd && pend && code == `SPR_ID_TMO);
   cover_rls_c: cover property (iir_rd && pend && code == `SPR_ID_RLS);
   cover_miss_c: cover property (io_rd && !addr_hit(io_addr, s.port_sel));
   cover_thre_c: cover property (iir_rd && pend && code == `SPR_ID_THRE);
   cover_full_c: cover property (s.fifo_en && rxq.level == LW'(DEPTH - 1));
endmodule

// ==== core/spr_defines.svh ====
/*
 * Register offsets, field positions, cause codes and timing counts
 * of the serial port register block. Assumes an 8-register window on
 * a byte-wide I/O bus and a 100 MHz core clock.
 */
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH

// Register offsets inside the 8-byte window
`define SPR_OFS_DATA 3'h0
`define SPR_OFS_IER 3'h1
`define SPR_OFS_IIR 3'h2
`define SPR_OFS_LCR 3'h3
`define SPR_OFS_SCR 3'h7

// Field positions
`define SPR_LCR_DIV_SEL 7
`define SPR_IER_RDA 0
`define SPR_IER_THRE 1
`define SPR_IER_RLS 2
`define SPR_IER_MS 3
`define SPR_FCR_EN 0
`define SPR_FCR_RX_CLR 1
`define SPR_FCR_TX_CLR 2

// Cause codes in identification bits 3:1
`define SPR_ID_MS 3'h0
`define SPR_ID_THRE 3'h1
`define SPR_ID_RDA 3'h2
`define SPR_ID_RLS 3'h3
`define SPR_ID_TMO 3'h6

// Receive trigger levels in bytes
`define SPR_TRIG_0 6'h01
`define SPR_TRIG_1 6'h04
`define SPR_TRIG_2 6'h08
`define SPR_TRIG_3 6'h0e

// Selectable base addresses
`define SPR_BASE_0 16'h03f8
`define SPR_BASE_1 16'h02f8
`define SPR_BASE_2 16'h03e8
`define SPR_BASE_3 16'h02e8

// Reference clock synthesised from the core clock
`define SPR_REF_HZ 27'd1843200
`define SPR_CLK_HZ 27'd100000000
// Four characters of ten bits at sixteen ticks a bit
`define SPR_TMO_TICKS 10'h280

`endif

// ==== core/spr_pkg.sv ====
/*
 * Types of the serial port register block: the state records of the
 * top module and of the bit-rate generator. Assumes spr_defines.svh.
 */
package spr_pkg;

   typedef logic [1:0] spr_trig_t;

   typedef struct packed {
      logic [26:0] acc;
      logic [15:0] cnt;
      logic tick;
   } spr_baud_s;

   typedef struct packed {
      logic [1:0] sel_s1;
      logic [1:0] sel_s2;
      logic [1:0] sel_s3;
      logic [1:0] port_sel;
      logic [7:0] ier;
      logic [7:0] lcr;
      logic [7:0] scr;
      logic [15:0] div;
      logic fifo_en;
      spr_trig_t trig;
      logic ls_f;
      logic rda_f;
      logic thre_f;
      logic ms_f;
      logic tmo_f;
      logic rda_lvl;
      logic tx_empty_q;
      logic [9:0] idle_cnt;
      logic [7:0] rdata;
      logic irq;
      logic [7:0] tx_data;
      logic tx_valid;
      logic rx_ready;
   } spr_regs_s;

endpackage

// ==== core/spr_fifo_if.sv ====
/*
 * Carrier between the register block and its byte queues: fill side,
 * drain side, flush and fill level. Assumes one clock for both sides.
 */
`timescale 1ns/1ns
interface spr_fifo_if #(parameter int W = 8, parameter int LW = 6);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic flush;
   logic [LW-1:0] level;

   modport fifo (input in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data, level);
   modport user (output in_valid, in_data, out_ready, flush,
                 input in_ready, out_valid, out_data, level);
endinterface

// ==== core/spr_fifo.sv ====
/*
 * Flip-flop byte queue with valid/ready on both sides and flush.
 * Assumes DEPTH is a power of two and LW equals log2(DEPTH)+1.
 */
`timescale 1ns/1ns
module spr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   spr_fifo_if.fifo q
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } spr_fifo_s;

   spr_fifo_s s;
   spr_fifo_s next_s;
   logic push;
   logic pop;

   // Flags and read port
   assign q.in_ready = s.cnt != (AW+1)'(DEPTH);
   assign q.out_valid = s.cnt != '0;
   assign q.out_data = s.mem[s.rd];
   assign q.level = s.cnt;
   assign push = q.in_valid & q.in_ready;
   assign pop = q.out_valid & q.out_ready;

   // Pointer and count update, flush wins
   always_comb begin
      next_s = s;
      if (q.flush) begin
         next_s.wr = '0;
         next_s.rd = '0;
         next_s.cnt = '0;
      end else begin
         if (push) begin
            next_s.mem[s.wr] = q.in_data;
            next_s.wr = AW'(s.wr + 1'b1);
         end
         if (pop) begin
            next_s.rd = AW'(s.rd + 1'b1);
         end
         next_s.cnt = (AW+1)'(s.cnt + push - pop);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   fifo_bound_a: assert property (@(posedge core_clk) disable iff (rst)
      s.cnt <= (AW+1)'(DEPTH))
      else $error("queue count above depth");
   fifo_step_a: assert property (@(posedge core_clk) disable iff (rst)
      push && !pop && !q.flush |=> s.cnt == $past(s.cnt) + 1'b1)
      else $error("queue count out of step");
endmodule

// ==== core/spr_baud.sv ====
/*
 * Bit-rate generator: synthesises the reference clock from the core
 * clock by phase accumulation, then divides it by the divisor latch.
 * Assumes the divisor is stable while in use; zero stops the ticks.
 */
`timescale 1ns/1ns
module spr_baud
   import spr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] div,
   output logic tick
);
`include "spr_defines.svh"

   spr_baud_s s;
   spr_baud_s next_s;
   logic [26:0] sum;
   logic ref_t;

   assign sum = 27'(s.acc + `SPR_REF_HZ);
   assign ref_t = sum >= `SPR_CLK_HZ;
   assign tick = s.tick;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      next_s.acc = ref_t ? 27'(sum - `SPR_CLK_HZ) : sum;
      if (div == 16'h0000) begin
         next_s.cnt = 16'h0000;
      end else if (ref_t) begin
         if (s.cnt <= 16'h0001) begin
            next_s.cnt = div;
            next_s.tick = 1'b1;
         end else begin
            next_s.cnt = 16'(s.cnt - 1'b1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   baud_tick_a: assert property (@(posedge core_clk) disable iff (rst)
      tick |-> $past(div) != 16'h0000 ##1 (!tick)[*8])
      else $error("bit tick faster than the reference allows");
endmodule

// ==== verification/spr_line_model.sv ====
/*
 * Line-side partner: offers received bytes on request and sinks
 * transmit bytes with a random or stalled ready.
 * Assumes rx_ready and tx_valid are registered on core_clk.
 */
`timescale 1ns/1ns
module spr_line_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic stall,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got[$];
   logic take = 1'b0;
   logic [7:0] td = 8'h00;
   logic [15:0] rnd = 16'h1d2b;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end

   // Offer one byte, hold it until taken, then scramble the line
   task send(input logic [7:0] b);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      do @(negedge core_clk); while (rx_ready !== 1'b1);
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_data <= ~b;
   endtask

   // Settled view of the transmit handshake
   always @(negedge core_clk) begin
      take <= (tx_valid === 1'b1) && tx_ready;
      td <= tx_data;
   end

   // Capture taken bytes, draw the next ready
   always @(posedge core_clk) begin
      if (take && !rst)
         got.push_back(td);
      rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      tx_ready <= !stall && rnd[0];
   end
endmodule

// ==== verification/testbench.sv ====
/*
 * Self-checking bench of the serial port register block: host
 * accesses, events, line traffic and timing.
 * Assumes spr_port as top and the line model beside it.
 */
`timescale 1ns/1ns
module testbench;
   logic core_clk = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0;
   logic rx_err = 1'b0, modem_chg = 1'b0, stall = 1'b0;
   logic [15:0] io_addr = 16'h0000, base = 16'h03f8;
   logic [7:0] io_wdata = 8'h00, io_rdata, rx_data, tx_data, v;
   logic [1:0] port_sel_pin = 2'h0;
   logic rx_valid, rx_ready, tx_valid, tx_ready, baud_tick, intr_pending;
   logic [31:0] lf = 32'd72140;
   logic [7:0] exp_q[$];
   int n_fail = 0, compares = 0, cyc = 0, n, k;
   localparam logic [7:0] TRIG[4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
   localparam logic [15:0] BASES[4] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8};

   always #5 core_clk = ~core_clk;

   spr_port #(.DEPTH(32)) i_spr_port (.core_clk(core_clk), .rst(rst), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .port_sel_pin(port_sel_pin), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .rx_err(rx_err), .modem_chg(modem_chg), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .baud_tick(baud_tick),
      .intr_pending(intr_pending));

   spr_line_model i_spr_line_model (.core_clk(core_clk), .rst(rst), .stall(stall),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Identification byte from queue mode, cause and pending state
   function automatic logic [7:0] iir(input logic fon, input logic [2:0] c, input logic p);
      return {{2{fon}}, 2'b00, c, ~p};
   endfunction

   task rnd8(output logic [7:0] r);
      lf = lfsr(lf);
      r = lf[7:0];
   endtask

   task finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   // Host write and read, one strobe cycle each
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_wr <= 1'b1;
      io_addr <= base | {13'h0, a};
      io_wdata <= d;
      @(posedge core_clk);
      io_wr <= 1'b0;
   endtask

   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      io_rd <= 1'b1;
      io_addr <= base | {13'h0, a};
      @(posedge core_clk);
      io_rd <= 1'b0;
      #1 d = io_rdata;
   endtask

   task rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd(a, g);
      chk(nm, e, g);
   endtask

   task put(input logic [7:0] b);
      i_spr_line_model.send(b);
      exp_q.push_back(b);
      repeat (3) @(posedge core_clk);
   endtask

   task pulse(input logic e, input logic m);
      @(posedge core_clk);
      rx_err <= e;
      modem_chg <= m;
      @(posedge core_clk);
      rx_err <= 1'b0;
      modem_chg <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task drain(input int cnt);
      for (int i = 0; i < cnt; i++)
         rdc("rx byte", 3'h0, exp_q.pop_front());
   endtask

   task set_div(input logic [7:0] lo);
      wr(3'h3, 8'h80);
      wr(3'h0, lo);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h00);
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      rdc("enables reset", 3'h1, 8'h00);
      rdc("idle id", 3'h2, iir(0, 3'h0, 0));
      chk("no pending", 8'h00, {7'h0, intr_pending});
      for (int i = 0; i < 4; i++) begin
         rnd8(v);
         wr(3'h7, v);
         rdc("scratch", 3'h7, v);
      end
      wr(3'h1, 8'hff);
      rdc("enables width", 3'h1, 8'h0f);
      wr(3'h1, 8'h05);
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h02);
      wr(3'h1, 8'h00);
      rdc("divisor low", 3'h0, 8'h02);
      rdc("divisor high", 3'h1, 8'h00);
      wr(3'h3, 8'h00);
      rdc("enables back", 3'h1, 8'h05);
      wr(3'h1, 8'h00);
      // Divisor 2: a tick every 108.5 cycles on average
      n = 0;
      repeat (10850) begin
         @(posedge core_clk);
         #1 if (baud_tick === 1'b1) n++;
      end
      chk("tick count", 8'd100, (n >= 99 && n <= 101) ? 8'd100 : n[7:0]);
      set_div(8'h00);
      wr(3'h2, 8'h07);
      wr(3'h1, 8'h02);
      rdc("tx empty", 3'h2, iir(1, 3'h1, 1));
      rdc("read clears", 3'h2, iir(1, 3'h0, 0));
      wr(3'h1, 8'h08);
      pulse(0, 1);
      chk("pending set", 8'h01, {7'h0, intr_pending});
      rdc("modem", 3'h2, iir(1, 3'h0, 1));
      wr(3'h1, 8'h04);
      pulse(1, 0);
      rdc("line status", 3'h2, iir(1, 3'h3, 1));
      wr(3'h1, 8'h0f);
      pulse(1, 1);
      rnd8(v);
      put(v);
      rdc("prio ls", 3'h2, iir(1, 3'h3, 1));
      rdc("prio rda", 3'h2, iir(1, 3'h2, 1));
      rdc("prio ms", 3'h2, iir(1, 3'h0, 1));
      rdc("prio none", 3'h2, iir(1, 3'h0, 0));
      drain(1);
      wr(3'h1, 8'h01);
      for (int t = 0; t < 4; t++) begin
         wr(3'h2, {t[1:0], 6'h07});
         for (int i = 1; i < TRIG[t]; i++) begin
            rnd8(v);
            put(v);
         end
         rdc("below trigger", 3'h2, iir(1, 3'h0, 0));
         rnd8(v);
         put(v);
         rdc("at trigger", 3'h2, iir(1, 3'h2, 1));
         drain(TRIG[t]);
      end
      wr(3'h2, 8'h07);
      put(8'h5a);
      put(8'ha5);
      wr(3'h2, 8'h03);
      exp_q.delete();
      rdc("rx flushed", 3'h2, iir(1, 3'h0, 0));
      wr(3'h2, 8'h00);
      rdc("queues off", 3'h2, iir(0, 3'h0, 0));
      wr(3'h2, 8'h07);
      wr(3'h1, 8'h00);
      for (int i = 0; i < 31; i++) begin
         rnd8(v);
         put(v);
      end
      chk("rx refused", 8'h00, {7'h0, rx_ready});
      drain(31);
      for (int s = 1; s < 4; s++) begin
         port_sel_pin <= s[1:0];
         repeat (8) @(posedge core_clk);
         rnd8(v);
         base = BASES[s];
         wr(3'h7, v);
         rdc("scratch at base", 3'h7, v);
         base = BASES[s-1];
         wr(3'h7, ~v);
         rdc("miss read", 3'h7, v);
         base = BASES[s];
         rdc("miss ignored", 3'h7, v);
      end
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rnd8(v);
         wr(3'h0, v);
         exp_q.push_back(v);
      end
      repeat (10) @(posedge core_clk);
      chk("tx held", 8'h00, 8'(i_spr_line_model.got.size()));
      stall <= 1'b0;
      repeat (60) @(posedge core_clk);
      chk("tx count", 8'h03, 8'(i_spr_line_model.got.size()));
      for (int i = 0; i < 3; i++)
         chk("tx byte", exp_q.pop_front(), i_spr_line_model.got.pop_front());
      i_spr_line_model.got.delete();
      stall <= 1'b1;
      for (int i = 0; i < 3; i++)
         wr(3'h0, 8'h3c);
      repeat (5) @(posedge core_clk);
      wr(3'h2, 8'h05);
      stall <= 1'b0;
      repeat (60) @(posedge core_clk);
      chk("tx flushed", 8'h01, (i_spr_line_model.got.size() <= 1) ? 8'h01 : 8'h00);
      // Divisor 1: 640 ticks take about 34720 cycles
      set_div(8'h01);
      wr(3'h2, 8'h47);
      wr(3'h1, 8'h01);
      put(8'h77);
      v = 8'h00;
      for (k = 0; k < 45 && v !== 8'hcc; k++) begin
         repeat (1000) @(posedge core_clk);
         rd(3'h2, v);
      end
      chk("timeout cause", iir(1, 3'h6, 1), v);
      chk("timeout late", 8'h01, (k >= 34) ? 8'h01 : 8'h00);
      finish_test();
   end
endmodule
